// [verilog/pwm_link_defs.svh]
// Purpose: shared constants of the pulse-width single-wire link
// Assumes: 100 MHz system clock
// Notes:   offsets are byte addresses of 32-bit words
`ifndef PWM_LINK_DEFS_SVH
`define PWM_LINK_DEFS_SVH
// ==========================================
// Timing
`define CLK_HZ        100000000
`define BIT_RATE_BPS  1200
`define SYNC_TICK_HZ  5000000
`define BREAK_TICK_HZ 131000
`define SIXTEENTHS    16
`define SYNC_SIXT     2
`define ZERO_SIXT     6
`define ONE_SIXT      12
`define SAMPLE_SIXT   9
// ==========================================
// Frame
`define PAUSE_SYMS    3
`define FRAME_BITS    19
`define FIRST_DATA    12
`define LAST_SYM      21
`define REG_WRITE_BIT 3
// ==========================================
// Register map
`define ADDR_STATUS   32'hffff077c
`define ADDR_CONTROL  32'hffff0780
`define ADDR_SYNC_CNT 32'hffff0784
`define ADDR_EDGES    32'hffff0788
`define ADDR_BRK_CNT  32'hffff078c
`define ADDR_PORT     32'hffff0790
`define ADDR_CAPTURE  32'hffff0794
`define ADDR_COMPARE  32'hffff0798
// ==========================================
// Fields and reset values
`define CTL_START_IE  3
`define CTL_CMP_IE    5
`define CTL_PWM_MODE  6
`define CTL_RISE_IE   8
`define STA_RISE      0
`define STA_START     1
`define STA_CMP       3
`define PORT_OUT      0
`define PORT_IN       4
`define RST_WORD      16'h0000
`define RST_STATUS    8'h00
`define BRK_SAT       16'hffff
`endif

// [verilog/pwm_link_pkg.sv]
// Purpose: types of the pulse-width single-wire link
// Assumes: nothing
// Notes:   constants live in pwm_link_defs.svh
`default_nettype none
package pwm_link_pkg;
	typedef enum logic {m_idle, m_run} master_state_t;
	typedef logic [15:0] word16_t;
endpackage : pwm_link_pkg
`default_nettype wire

// [verilog/pwm_link_if.sv]
// Purpose: open-drain single wire between device and far node
// Assumes: either end pulls low by raising its enable
// Notes:   wire level resolved here, high when nobody pulls
`timescale 1ns/1ns
`default_nettype none
interface pwm_link_if;
	logic dev_o;
	logic dev_oe;
	logic far_o;
	logic far_oe;
	logic line;
	assign line = ~((dev_oe & ~dev_o) | (far_oe & ~far_o));
	modport device (output dev_o, output dev_oe, input line);
	modport far    (output far_o, output far_oe, input line);
endinterface : pwm_link_if
`default_nettype wire

// [verilog/req_fifo.sv]
// Purpose: request queue in front of the far node
// Assumes: single clock
// Notes:   DEPTH must be a power of two
`timescale 1ns/1ns
`default_nettype none
module req_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
	logic             push, pop;
	// ==========================================
	// Pointers, one spare bit tells full from empty
	always_comb begin
		in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
		out_valid = wp_q != rp_q;
		push      = in_valid & in_ready;
		pop       = out_valid & out_ready;
		wp_d      = push ? wp_q + 1'b1 : wp_q;
		rp_d      = pop ? rp_q + 1'b1 : rp_q;
		out_data  = mem[rp_q[AW-1:0]];
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end
	// Storage needs no reset
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end
endmodule : req_fifo
`default_nettype wire

// [verilog/pwm_link_far.sv]
// Purpose: far node acting as bus master of the single wire
// Assumes: device end answers as slave; wire synchronous
// Notes:   request {reg_addr[3:0], slave[2:0], data[7:0]}, MSB first
`include "pwm_link_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pwm_link_far #(
	parameter int BIT_CYCLES = `CLK_HZ/`BIT_RATE_BPS,
	parameter int DEPTH      = 16
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	pwm_link_if.far          link,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [14:0] req_data,
	output logic             resp_valid,
	output logic      [7:0]  resp_data,
	output logic             resp_ack,
	output logic             resp_perr
);
	localparam int SYNC_LEN = BIT_CYCLES*`SYNC_SIXT/`SIXTEENTHS;
	localparam int ZERO_LEN = BIT_CYCLES*`ZERO_SIXT/`SIXTEENTHS;
	localparam int ONE_LEN  = BIT_CYCLES*`ONE_SIXT/`SIXTEENTHS;
	localparam int SMP_LEN  = BIT_CYCLES*`SAMPLE_SIXT/`SIXTEENTHS;
	pwm_link_pkg::master_state_t st_q, st_d;
	logic [14:0] fifo_data;
	logic        fifo_valid, fifo_ready;
	logic [31:0] cyc_q, cyc_d, low_len;
	logic [4:0]  idx_q, idx_d;
	logic [18:0] frm_q, frm_d;
	logic [9:0]  rx_q, rx_d;
	logic        rd_q, rd_d, oe_q, oe_d, pause, slv;
	logic        rv_q, rv_d, ack_q, ack_d, pe_q, pe_d;
	logic [7:0]  rdat_q, rdat_d, hdr;
	logic [7:0]  wd_q, wd_d;
	req_fifo #(.WIDTH(15), .DEPTH(DEPTH)) req_fifo_inst (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   (req_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);
	assign link.far_o  = 1'b0;
	assign link.far_oe = oe_q;
	assign resp_valid  = rv_q;
	assign resp_data   = rdat_q;
	assign resp_ack    = ack_q;
	assign resp_perr   = pe_q;
	// ==========================================
	// Frame sequencer
	always_comb begin
		st_d = st_q;
		cyc_d = cyc_q;
		idx_d = idx_q;
		frm_d = frm_q;
		rx_d = rx_q;
		rd_d = rd_q;
		rv_d = 1'b0;
		rdat_d = rdat_q;
		wd_d = wd_q;
		ack_d = ack_q;
		pe_d = pe_q;
		fifo_ready = st_q == pwm_link_pkg::m_idle;
		hdr = {1'b0, fifo_data[10:8], fifo_data[14:11]};
		pause = idx_q < 5'(`PAUSE_SYMS);
		slv = (idx_q == 5'(`LAST_SYM)) | (rd_q & idx_q >= 5'(`FIRST_DATA));
		if (pause | slv) begin
			low_len = 32'(SYNC_LEN);
		end else begin
			low_len = frm_q[18] ? 32'(ONE_LEN) : 32'(ZERO_LEN);
		end
		oe_d = (st_q == pwm_link_pkg::m_run) & (cyc_q < low_len);
		case (st_q)
			pwm_link_pkg::m_idle: begin
				if (fifo_valid) begin
					st_d = pwm_link_pkg::m_run;
					cyc_d = '0;
					idx_d = '0;
					rx_d = '0;
					rd_d = ~fifo_data[11 + `REG_WRITE_BIT];
					// Frame register shifts the data out, so keep a copy for the response
					wd_d = fifo_data[7:0];
					frm_d = {hdr, ^hdr, fifo_data[7:0], ^fifo_data[7:0], 1'b1};
				end
			end
			default: begin
				cyc_d = cyc_q + 32'h1;
				if (slv & cyc_q == 32'(SMP_LEN)) begin
					rx_d = {rx_q[8:0], ~link.line};
				end
				if (cyc_q == 32'(BIT_CYCLES - 1)) begin
					cyc_d = '0;
					if (!pause) begin
						frm_d = {frm_q[17:0], 1'b0};
					end
					if (idx_q == 5'(`LAST_SYM)) begin
						st_d = pwm_link_pkg::m_idle;
						rv_d = 1'b1;
						ack_d = rx_q[0];
						rdat_d = rd_q ? rx_q[9:2] : wd_q;
						pe_d = rd_q & (^rx_q[9:1]);
					end else begin
						idx_d = idx_q + 5'h1;
					end
				end
			end
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= pwm_link_pkg::m_idle;
			cyc_q <= '0;
			idx_q <= '0;
			frm_q <= '0;
			rx_q <= '0;
			rd_q <= 1'b0;
			oe_q <= 1'b0;
			rv_q <= 1'b0;
			rdat_q <= '0;
			wd_q <= '0;
			ack_q <= 1'b0;
			pe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cyc_q <= cyc_d;
			idx_q <= idx_d;
			frm_q <= frm_d;
			rx_q <= rx_d;
			rd_q <= rd_d;
			oe_q <= oe_d;
			rv_q <= rv_d;
			rdat_q <= rdat_d;
			wd_q <= wd_d;
			ack_q <= ack_d;
			pe_q <= pe_d;
		end
	end
endmodule : pwm_link_far
`default_nettype wire

// [verilog/pwm_link_device.sv]
// Purpose: timing assist of a software-driven pulse-width link
// Assumes: wire level synchronous to sys_clk
// Notes:   software forms symbols via the port output bit
`include "pwm_link_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pwm_link_device #(
	parameter int SYNC_DIV  = `CLK_HZ/`SYNC_TICK_HZ,
	parameter int BREAK_DIV = `CLK_HZ/`BREAK_TICK_HZ
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	pwm_link_if.device       link,
	input  wire logic        reg_sel,
	input  wire logic        reg_wr,
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             irq
);
	pwm_link_pkg::word16_t sdiv_q, sdiv_d;
	pwm_link_pkg::word16_t bdiv_q, bdiv_d;
	pwm_link_pkg::word16_t sync_q, sync_d;
	pwm_link_pkg::word16_t cap_q, cap_d;
	pwm_link_pkg::word16_t cmp_q, cmp_d;
	pwm_link_pkg::word16_t ctl_q, ctl_d;
	pwm_link_pkg::word16_t edg_q, edg_d;
	pwm_link_pkg::word16_t brk_q, brk_d;
	logic [7:0]  sta_q, sta_d;
	logic [7:0]  set, clr;
	logic [31:0] rd_q, rd_d;
	logic        run_q, run_d;
	logic        out_q, out_d;
	logic        line_q;
	logic        oe_q, oe_d;
	logic        irq_q, irq_d;
	logic        fall, rise, stick, btick, pwm, wr;
	assign link.dev_o  = 1'b0;
	assign link.dev_oe = oe_q;
	assign reg_rdata   = rd_q;
	assign irq         = irq_q;
	// One-step count shared by both timers
	function automatic pwm_link_pkg::word16_t step_up(input pwm_link_pkg::word16_t v);
		return v + 16'h1;
	endfunction : step_up
	// ==========================================
	// Tick dividers
	always_comb begin
		// Reload at zero, so each tick lasts one clock
		stick  = sdiv_q == '0;
		btick  = bdiv_q == '0;
		sdiv_d = stick ? 16'(SYNC_DIV - 1) : sdiv_q - 16'h1;
		bdiv_d = btick ? 16'(BREAK_DIV - 1) : bdiv_q - 16'h1;
	end
	// ==========================================
	// Timers, capture, compare, status
	always_comb begin
		fall = line_q & ~link.line;
		rise = ~line_q & link.line;
		pwm  = ctl_q[`CTL_PWM_MODE];
		wr   = reg_sel & reg_wr;
		set  = '0;
		clr  = '0;
		ctl_d = ctl_q;
		edg_d = edg_q;
		cmp_d = cmp_q;
		out_d = out_q;
		// Outside pulse mode nothing else uses the timer,
		// so it is held at zero here.
		if (!pwm) begin
			sync_d = '0;
		end else if (stick) begin
			sync_d = step_up(sync_q);
		end else begin
			sync_d = sync_q;
		end
		// Edge seen in the cycle the wire changes; line_q holds the level from the clock before
		cap_d = (pwm & fall) ? sync_q : cap_q;
		// Match seen only on the tick that reaches the value,
		// so the flag cannot refire while the timer holds still.
		if (pwm & stick & ctl_q[`CTL_CMP_IE] & (sync_d == cmp_q)) begin
			set[`STA_CMP] = 1'b1;
		end
		if (fall & ctl_q[`CTL_START_IE]) begin
			set[`STA_START] = 1'b1;
		end
		run_d = run_q;
		brk_d = brk_q;
		if (pwm & fall) begin
			brk_d = '0;
			run_d = 1'b1;
		end else if (rise & run_q) begin
			run_d = 1'b0;
			if (ctl_q[`CTL_RISE_IE]) begin
				set[`STA_RISE] = 1'b1;
			end
		end else if (run_q & btick & (brk_q != `BRK_SAT)) begin
			// Saturates, so an over-long low still reads as long
			brk_d = step_up(brk_q);
		end
		if (wr) begin
			if (reg_addr == `ADDR_CONTROL) begin
				ctl_d = reg_wdata[15:0];
			end else if (reg_addr == `ADDR_STATUS) begin
				// Writing one clears a flag
				clr = reg_wdata[7:0];
			end else if (reg_addr == `ADDR_EDGES) begin
				edg_d = reg_wdata[15:0];
			end else if (reg_addr == `ADDR_COMPARE) begin
				cmp_d = reg_wdata[15:0];
			end else if (reg_addr == `ADDR_PORT) begin
				// Low pulls the wire; reset leaves it released
				out_d = reg_wdata[`PORT_OUT];
			end
		end
		// Set beats a clear landing in the same cycle
		sta_d = (sta_q & ~clr) | set;
		// Level request, high until every flag is cleared
		irq_d = |sta_d;
		oe_d  = ~out_d;
	end
	// ==========================================
	// Read decode, one cycle latency
	always_comb begin
		rd_d = '0;
		// Writes and unmapped addresses read as zero
		if (reg_sel & ~reg_wr) begin
			if (reg_addr == `ADDR_STATUS) begin
				rd_d = {24'h0, sta_q};
			end else if (reg_addr == `ADDR_CONTROL) begin
				rd_d = {16'h0, ctl_q};
			end else if (reg_addr == `ADDR_SYNC_CNT) begin
				rd_d = {16'h0, sync_q};
			end else if (reg_addr == `ADDR_EDGES) begin
				rd_d = {16'h0, edg_q};
			end else if (reg_addr == `ADDR_BRK_CNT) begin
				rd_d = {16'h0, brk_q};
			end else if (reg_addr == `ADDR_PORT) begin
				rd_d[`PORT_OUT] = out_q;
				rd_d[`PORT_IN]  = line_q;
			end else if (reg_addr == `ADDR_CAPTURE) begin
				rd_d = {16'h0, cap_q};
			end else if (reg_addr == `ADDR_COMPARE) begin
				rd_d = {16'h0, cmp_q};
			end
		end
	end
	// ==========================================
	// State registers
	// Wire level is kept for edge detection and readback
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sdiv_q <= '0;
			bdiv_q <= '0;
			sync_q <= `RST_WORD;
			cap_q  <= `RST_WORD;
			cmp_q  <= `RST_WORD;
			ctl_q  <= `RST_WORD;
			edg_q  <= `RST_WORD;
			brk_q  <= `RST_WORD;
			sta_q  <= `RST_STATUS;
			rd_q   <= '0;
			run_q  <= 1'b0;
			out_q  <= 1'b1;
			line_q <= 1'b1;
			oe_q   <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			sdiv_q <= sdiv_d;
			bdiv_q <= bdiv_d;
			sync_q <= sync_d;
			cap_q  <= cap_d;
			cmp_q  <= cmp_d;
			ctl_q  <= ctl_d;
			edg_q  <= edg_d;
			brk_q  <= brk_d;
			sta_q  <= sta_d;
			rd_q   <= rd_d;
			run_q  <= run_d;
			out_q  <= out_d;
			line_q <= link.line;
			oe_q   <= oe_d;
			irq_q  <= irq_d;
		end
	end
endmodule : pwm_link_device
`default_nettype wire

// [tb/pwm_link_checker_sva.sv]
// Purpose: wire-level checks of the pulse-width link
// Assumes: device end stays released while frames run
// Notes:   widths counted in sys_clk cycles
`timescale 1ns/1ns
`default_nettype none
module pwm_link_checker #(
	parameter int BIT_CYCLES = 192
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic far_o,
	input wire logic far_oe,
	input wire logic line
);
	localparam int SY = BIT_CYCLES*2/16;
	localparam int ZE = BIT_CYCLES*6/16;
	localparam int ON = BIT_CYCLES*12/16;
	logic [15:0] hi_q, hi_d, gap_q, gap_d;
	logic        oe_q, seen_q, seen_d, rise;
	// ==========================================
	// Pulse and period counters
	always_comb begin
		rise = far_oe & ~oe_q;
		hi_d = far_oe ? hi_q + 16'h1 : 16'h0;
		gap_d = rise ? 16'h1 : (&gap_q ? gap_q : gap_q + 16'h1);
		seen_d = seen_q | rise;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_q <= 16'h0;
			gap_q <= 16'h0;
			oe_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			hi_q <= hi_d;
			gap_q <= gap_d;
			oe_q <= far_oe;
			seen_q <= seen_d;
		end
	end
	// ==========================================
	// Properties
	default clocking dcb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_open_drain; dev_o == 1'b0 && far_o == 1'b0; endproperty
	property p_reset_quiet; $rose(rst_b) |-> !far_oe && !dev_oe; endproperty
	property p_low_width;
		$fell(far_oe) |-> hi_q inside {[SY-1:SY+1], [ZE-1:ZE+1], [ON-1:ON+1]};
	endproperty
	property p_high_cap; hi_q <= ON + 1; endproperty
	property p_bit_period; rise && seen_q |-> gap_q >= BIT_CYCLES - 1; endproperty
	property p_hold_low; rise |-> far_oe [*8]; endproperty
	property p_release_gap; $fell(far_oe) |-> !far_oe [*8]; endproperty
	property p_start_idle; rise |-> $past(line); endproperty
	a_open_drain: assert property (p_open_drain) else $error("link pin driven high");
	a_reset_quiet: assert property (p_reset_quiet) else $error("wire pulled at reset");
	a_low_width: assert property (p_low_width) else $error("bad symbol low time");
	a_high_cap: assert property (p_high_cap) else $error("low pulse too long");
	a_bit_period: assert property (p_bit_period) else $error("bit period short");
	a_hold_low: assert property (p_hold_low) else $error("sync pulse too short");
	a_release_gap: assert property (p_release_gap) else $error("release too short");
	a_start_idle: assert property (p_start_idle) else $error("bit began on low wire");
	c_bit: cover property (rise);
	c_one: cover property ($fell(far_oe) && hi_q > ZE + 1);
	c_dev: cover property ($rose(dev_oe));
endmodule : pwm_link_checker
`default_nettype wire

// [tb/pwm_single_wire_bit_timer_bench.sv]
// Purpose: bench of both link ends facing each other
// Assumes: device end stays released while far end frames
// Notes:   short bit period keeps the run brief
`include "pwm_link_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pwm_single_wire_bit_timer_bench;
	localparam int BC = 192;
	localparam int SY = BC*2/16;
	localparam int ZE = BC*6/16;
	localparam int ON = BC*12/16;
	logic        sys_clk = '0, rst_b = '0, reg_sel = '0, reg_wr = '0, req_valid = '0;
	logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
	logic [14:0] req_data = '0;
	logic        irq, req_ready, resp_valid, resp_ack, resp_perr;
	logic [7:0]  resp_data;
	logic [31:0] seed = 32'h5c;
	int          fails = 0, total_checks = 0, lw = 0;
	int          sym_q[$];
	logic [9:0]  resp_q[$];
	// ==========================================
	// Design and checker
	pwm_link_if pwm_link_if_inst ();
	pwm_link_device #(.SYNC_DIV(2), .BREAK_DIV(4)) pwm_link_device_inst (.sys_clk(sys_clk), .rst_b(rst_b),
		.link(pwm_link_if_inst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq));
	pwm_link_far #(.BIT_CYCLES(BC), .DEPTH(16)) pwm_link_far_inst (.sys_clk(sys_clk), .rst_b(rst_b),
		.link(pwm_link_if_inst), .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
		.resp_valid(resp_valid), .resp_data(resp_data), .resp_ack(resp_ack), .resp_perr(resp_perr));
	pwm_link_checker #(.BIT_CYCLES(BC)) pwm_link_checker_inst (.sys_clk(sys_clk), .rst_b(rst_b),
		.dev_o(pwm_link_if_inst.dev_o), .dev_oe(pwm_link_if_inst.dev_oe), .far_o(pwm_link_if_inst.far_o),
		.far_oe(pwm_link_if_inst.far_oe), .line(pwm_link_if_inst.line));
	always #5 sys_clk = ~sys_clk;
	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
		total_checks++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			$display("wrong value %s expected %h..%h seen %h", nm, lo, hi, g);
			fails++;
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge sys_clk);
		reg_sel = 1'b1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_sel = 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(negedge sys_clk);
		reg_sel = 1'b1;
		reg_wr = 1'b0;
		reg_addr = a;
		@(negedge sys_clk);
		reg_sel = 1'b0;
		d = reg_rdata;
	endtask : rd
	// Expected wire symbols and response of one request
	task automatic note(input logic [14:0] d);
		logic [7:0] h;
		int i;
		h = {1'b0, d[10:8], d[14:11]};
		repeat (3) sym_q.push_back(SY);
		for (i = 7; i >= 0; i--) sym_q.push_back(h[i] ? ON : ZE);
		sym_q.push_back(^h ? ON : ZE);
		for (i = 7; i >= 0; i--) sym_q.push_back(!d[14] ? SY : d[i] ? ON : ZE);
		sym_q.push_back(!d[14] ? SY : ^d[7:0] ? ON : ZE);
		sym_q.push_back(SY);
		resp_q.push_back({2'b00, d[14] ? d[7:0] : 8'h00});
	endtask : note
	// Ready is flop-driven, so it is read before the taking edge
	task automatic send(input logic [14:0] d, output logic ok);
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_data = d;
		ok = req_ready;
		if (ok === 1'b1) note(d);
		@(negedge sys_clk);
		req_valid = 1'b0;
	endtask : send
	// ==========================================
	// Monitors
	always @(negedge sys_clk) begin
		if (pwm_link_if_inst.line === 1'b0) lw++;
		else if (lw > 0) begin
			if (sym_q.size() > 0) begin
				chk("low width", sym_q[0] - 1, sym_q[0] + 1, lw);
				void'(sym_q.pop_front());
			end
			lw = 0;
		end
		if (resp_valid === 1'b1 && resp_q.size() > 0) begin
			chk("response", resp_q[0], resp_q[0], {resp_ack, resp_perr, resp_data});
			void'(resp_q.pop_front());
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] a, b;
		int n;
		logic ok;
		repeat (5) @(negedge sys_clk);
		rst_b = 1'b1;
		rd(`ADDR_CAPTURE, a);
		chk("capture reset", 0, 0, a);
		rd(`ADDR_COMPARE, a);
		chk("compare reset", 0, 0, a);
		rd(32'hffff07a0, a);
		chk("unmapped", 0, 0, a);
		wr(`ADDR_CAPTURE, 32'h1234);
		rd(`ADDR_CAPTURE, a);
		chk("capture read only", 0, 0, a);
		rd(`ADDR_SYNC_CNT, a);
		chk("timer idle", 0, 0, a);
		wr(`ADDR_EDGES, 32'h5a);
		rd(`ADDR_EDGES, a);
		chk("edge setup", 32'h5a, 32'h5a, a);
		wr(`ADDR_CONTROL, 32'h168);
		rd(`ADDR_SYNC_CNT, a);
		rd(`ADDR_SYNC_CNT, b);
		chk("timer runs", a + 1, a + 2, b);
		wr(`ADDR_PORT, 32'h0);
		repeat (40) @(negedge sys_clk);
		chk("wire low", 0, 0, pwm_link_if_inst.line);
		rd(`ADDR_PORT, b);
		chk("wire level bit", 0, 0, b[4]);
		wr(`ADDR_PORT, 32'h1);
		rd(`ADDR_CAPTURE, b);
		chk("capture", a + 1, a + 6, b);
		rd(`ADDR_BRK_CNT, b);
		chk("break width", 8, 13, b);
		rd(`ADDR_STATUS, b);
		chk("status", 3, 3, b);
		chk("irq", 1, 1, irq);
		wr(`ADDR_STATUS, 32'hb);
		repeat (2) @(negedge sys_clk);
		chk("irq cleared", 0, 0, irq);
		rd(`ADDR_SYNC_CNT, a);
		wr(`ADDR_COMPARE, {16'h0, a[15:0] + 16'h14});
		rd(`ADDR_COMPARE, b);
		chk("compare", {16'h0, a[15:0] + 16'h14}, {16'h0, a[15:0] + 16'h14}, b);
		for (n = 0; n < 200 && irq !== 1'b1; n++) @(negedge sys_clk);
		if (n == 200) fails++;
		if (n == 200) finish_test();
		rd(`ADDR_STATUS, b);
		chk("compare flag", 8, 8, b);
		wr(`ADDR_STATUS, 32'hb);
		repeat (300) @(negedge sys_clk);
		chk("no repeat", 0, 0, irq);
		n = 0;
		ok = 1'b1;
		while (ok === 1'b1 && n < 20) begin
			a = rnd();
			send({n[0], a[13:0]}, ok);
			n++;
		end
		chk("queue refusal", 17, 18, n);
		for (n = 0; n < 90000 && resp_q.size() > 0; n++) @(negedge sys_clk);
		if (n == 90000) fails++;
		if (n == 90000) finish_test();
		chk("symbols left", 0, 0, sym_q.size());
		rd(`ADDR_BRK_CNT, b);
		chk("ack width", 5, 7, b);
		finish_test();
	end
endmodule : pwm_single_wire_bit_timer_bench
`default_nettype wire
